// File: logic/ccss_consts.vh
// Constants for the clock source select and start-up block.
// Assumes plain Verilog-2005 inclusion by bare name; definitions only.
`ifndef CCSS_CONSTS_VH
`define CCSS_CONSTS_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define CCSS_ADDR_W 8
`define CCSS_DATA_W 8
`define CCSS_REG_CTRL 8'h00
`define CCSS_REG_STAT 8'h01
`define CCSS_REG_FUSE 8'h02
`define CCSS_CTRL_RST 8'h38
`define CCSS_CTRL_MODE_LSB 0
`define CCSS_CTRL_IO_EN 3
`define CCSS_CTRL_ASY_EN 4
`define CCSS_CTRL_ADC_EN 5

// ---------------------------------------------------------------
// Clock sources and start-up delay codes
// ---------------------------------------------------------------
`define CCSS_SRC_XTAL 3'h0
`define CCSS_SRC_LFXT 3'h1
`define CCSS_SRC_ERC 3'h2
`define CCSS_SRC_IRC 3'h3
`define CCSS_SRC_EXT 3'h4
`define CCSS_DLY_NONE 2'h0
`define CCSS_DLY_SHORT 2'h1
`define CCSS_DLY_LONG 2'h2

// ---------------------------------------------------------------
// Sleep modes
// ---------------------------------------------------------------
`define CCSS_SLP_IDLE 3'h0
`define CCSS_SLP_ADCNR 3'h1
`define CCSS_SLP_PDOWN 3'h2
`define CCSS_SLP_PSAVE 3'h3
`define CCSS_SLP_STBY 3'h6
`define CCSS_SLP_XSTBY 3'h7

// ---------------------------------------------------------------
// Start-up counts, in cycles of the counted oscillator
// ---------------------------------------------------------------
`define CCSS_CNT_W 17
`define CCSS_CK_6 17'h00006
`define CCSS_CK_18 17'h00012
`define CCSS_CK_258 17'h00102
`define CCSS_CK_1K 17'h00400
`define CCSS_CK_16K 17'h04000
`define CCSS_CK_32K 17'h08000
`define CCSS_WDT_SHORT 4096
`define CCSS_WDT_LONG 65536

// ---------------------------------------------------------------
// Factory fuse defaults (0 = programmed)
// ---------------------------------------------------------------
`define CCSS_FUSE_CKSEL_DFLT 4'h1
`define CCSS_FUSE_SUT_DFLT 2'h2

`endif

// File: logic/ccss_sync3.v
// Three-stage synchroniser for a pin level, with rising-edge pulse.
// Assumes an asynchronous input; output moves when stages two and three agree.
`timescale 1ns/1ps
module ccss_sync3 (
   input wire clk,
   input wire rst_n,
   input wire din,
   output reg level_q,
   output wire rise
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // Shift chain; only stage two reads stage one
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign rise = (s2_q == s3_q) && s3_q && !level_q;
endmodule

// File: logic/ccss_tick_timer.v
// Down counter that loads a count and steps once per tick.
// Assumes load and tick come from logic on the same clock.
`timescale 1ns/1ps
module ccss_tick_timer #(
   parameter W = 17
) (
   input wire clk,
   input wire rst_n,
   input wire load,
   input wire [W-1:0] load_val,
   input wire tick,
   output wire zero
);
   reg [W-1:0] cnt_q;

   // Load wins over a tick in the same cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= {W{1'b0}};
      end else if (load) begin
         cnt_q <= load_val;
      end else if (tick && (cnt_q != {W{1'b0}})) begin
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign zero = (cnt_q == {W{1'b0}});
endmodule

// File: logic/ccss_top.v
// Clock source select, start-up timing and clock domain gating.
// Assumes fuses are stable pins, oscillator and watchdog clocks arrive as pins.
//
// Summary of operation
// - Fuse code 1111-1010 crystal, 1001 low-freq, 1000-0101 RC, 0100-0001 internal, 0000 external.
// - A fuse bit of one is unprogrammed, zero is programmed.
// - Wake from power-down or power-save waits start-up cycles of selected source.
// - Reset start adds a delay counted on the watchdog oscillator, except where the delay code is none.
// - Factory defaults 0001 and 10 select 1 MHz internal RC, longest start.
// - Crystal range bits 101/110/111 rise in range; programmed option means wide.
// - Option fuse programmed gives full swing wide range; else low-power swing.
// - Crystal, select bit zero 0: 258+4.1ms, 258+65ms, 1K+none, 1K+4.1ms.
// - Crystal, select bit zero 1: 1K+65ms, 16K+none, 16K+4.1ms, 16K+65ms.
// - Core clock drives register file, flags and stack; gating stops the core.
// - Peripheral clock drives timers, SPI, serial port; async detectors need none.
// - Asynchronous timer clock domain keeps running through sleep, except in power-down and standby.
// - Converter clock domain runs while core and peripheral clocks stop.
// - Unused module clocks gate off independently under sleep mode control.
// - Flash interface clock follows the core clock.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "ccss_consts.vh"
module ccss_top #(
   parameter WDT_SHORT = `CCSS_WDT_SHORT,
   parameter WDT_LONG = `CCSS_WDT_LONG
) (
   input wire clk,
   input wire rst_n,
   input wire [3:0] clock_source_select_fuses,
   input wire [1:0] startup_time_fuses,
   input wire oscillator_amplifier_option_fuse,
   input wire osc_clk_pin,
   input wire watchdog_oscillator_pin,
   input wire wake_pin,
   input wire sleep_enter,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   output reg core_reset_n,
   output reg exec_hold,
   output reg cpu_clk_en,
   output reg flash_clk_en,
   output reg io_clk_en,
   output reg asy_clk_en,
   output reg adc_clk_en,
   output reg [2:0] osc_sel,
   output reg amp_full_swing,
   output reg [1:0] xtal_range
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam ST_FUSE = 3'h0;
   localparam ST_OSC = 3'h1;
   localparam ST_WDT = 3'h2;
   localparam ST_RUN = 3'h3;
   localparam ST_SLEEP = 3'h4;
   localparam ST_WAKE = 3'h5;

   // ---------------------------------------------------------------
   // Fuse decoding functions
   // ---------------------------------------------------------------
   // Source from the four select fuses
   function [2:0] src_of;
      input [3:0] ck;
      begin
         if (ck >= 4'hA) src_of = `CCSS_SRC_XTAL;
         else if (ck == 4'h9) src_of = `CCSS_SRC_LFXT;
         else if (ck >= 4'h5) src_of = `CCSS_SRC_ERC;
         else if (ck >= 4'h1) src_of = `CCSS_SRC_IRC;
         else src_of = `CCSS_SRC_EXT;
      end
   endfunction

   // Start-up cycles of the selected source
   function [16:0] ck_of;
      input [3:0] ck;
      input [1:0] startup_fuse_field;
      begin
         case (src_of(ck))
            `CCSS_SRC_XTAL: begin
               if (!ck[0]) ck_of = startup_fuse_field[1] ? `CCSS_CK_1K : `CCSS_CK_258;
               else ck_of = (startup_fuse_field == 2'h0) ? `CCSS_CK_1K : `CCSS_CK_16K;
            end
            `CCSS_SRC_LFXT: ck_of = startup_fuse_field[1] ? `CCSS_CK_32K : `CCSS_CK_1K;
            `CCSS_SRC_ERC: ck_of = (startup_fuse_field == 2'h3) ? `CCSS_CK_6 : `CCSS_CK_18;
            default: ck_of = `CCSS_CK_6;
         endcase
      end
   endfunction

   // Additional reset delay code
   function [1:0] dly_of;
      input [3:0] ck;
      input [1:0] startup_fuse_field;
      begin
         case (src_of(ck))
            `CCSS_SRC_XTAL: begin
               case ({ck[0], startup_fuse_field})
                  3'h0: dly_of = `CCSS_DLY_SHORT;
                  3'h1: dly_of = `CCSS_DLY_LONG;
                  3'h2: dly_of = `CCSS_DLY_NONE;
                  3'h3: dly_of = `CCSS_DLY_SHORT;
                  3'h4: dly_of = `CCSS_DLY_LONG;
                  3'h5: dly_of = `CCSS_DLY_NONE;
                  3'h6: dly_of = `CCSS_DLY_SHORT;
                  default: dly_of = `CCSS_DLY_LONG;
               endcase
            end
            `CCSS_SRC_LFXT: dly_of = (startup_fuse_field == 2'h0) ? `CCSS_DLY_SHORT : `CCSS_DLY_LONG;
            `CCSS_SRC_ERC: begin
               if (startup_fuse_field == 2'h0) dly_of = `CCSS_DLY_NONE;
               else if (startup_fuse_field == 2'h2) dly_of = `CCSS_DLY_LONG;
               else dly_of = `CCSS_DLY_SHORT;
            end
            default: begin
               if (startup_fuse_field == 2'h0) dly_of = `CCSS_DLY_NONE;
               else if (startup_fuse_field == 2'h1) dly_of = `CCSS_DLY_SHORT;
               else dly_of = `CCSS_DLY_LONG;
            end
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   reg [3:0] cksel_q;
   reg [1:0] sut_q;
   reg opt_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg tmr_ld_q;
   reg tmr_ld_d;
   reg [16:0] tmr_val_q;
   reg [16:0] tmr_val_d;
   reg [7:0] ctrl_q;
   reg [2:0] slp_mode_q;
   wire osc_rise;
   wire wdt_rise;
   wire wake_lvl;
   wire tmr_zero;
   wire tmr_tick;
   wire tmr_done;
   wire [1:0] dly_code;
   wire [16:0] wdt_cnt;
   wire [2:0] slp_mode_now;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   ccss_sync3 u_osc_sync (.clk(clk), .rst_n(rst_n), .din(osc_clk_pin), .level_q(),
      .rise(osc_rise));
   ccss_sync3 u_wdt_sync (.clk(clk), .rst_n(rst_n), .din(watchdog_oscillator_pin), .level_q(),
      .rise(wdt_rise));
   ccss_sync3 u_wake_sync (.clk(clk), .rst_n(rst_n), .din(wake_pin), .level_q(wake_lvl),
      .rise());

   // ---------------------------------------------------------------
   // Shared start-up counter
   // ---------------------------------------------------------------
   // Watchdog edges during the reset delay, source edges otherwise
   assign tmr_tick = (state_q == ST_WDT) ? wdt_rise : osc_rise;
   assign tmr_done = tmr_zero && !tmr_ld_q;

   ccss_tick_timer #(.W(`CCSS_CNT_W)) u_timer (.clk(clk), .rst_n(rst_n), .load(tmr_ld_q),
      .load_val(tmr_val_q), .tick(tmr_tick), .zero(tmr_zero));

   // ---------------------------------------------------------------
   // Fuse capture
   // ---------------------------------------------------------------
   // Defaults under reset, real fuses taken once after release
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cksel_q <= `CCSS_FUSE_CKSEL_DFLT;
         sut_q <= `CCSS_FUSE_SUT_DFLT;
         opt_q <= 1'b1;
      end else if (state_q == ST_FUSE) begin
         cksel_q <= clock_source_select_fuses;
         sut_q <= startup_time_fuses;
         opt_q <= oscillator_amplifier_option_fuse;
      end
   end

   assign dly_code = dly_of(cksel_q, sut_q);
   assign wdt_cnt = (dly_code == `CCSS_DLY_LONG) ? WDT_LONG[16:0] : WDT_SHORT[16:0];
   // Mode in force: control field on the entry edge, frozen copy while asleep
   assign slp_mode_now = (state_q == ST_RUN) ?
      ctrl_q[`CCSS_CTRL_MODE_LSB+2:`CCSS_CTRL_MODE_LSB] : slp_mode_q;

   // ---------------------------------------------------------------
   // Start-up and sleep sequencer
   // ---------------------------------------------------------------
   always @* begin
      state_d = state_q;
      tmr_ld_d = 1'b0;
      tmr_val_d = tmr_val_q;
      case (state_q)
         ST_FUSE: begin
            state_d = ST_OSC;
            tmr_ld_d = 1'b1;
            tmr_val_d = ck_of(clock_source_select_fuses, startup_time_fuses);
         end
         ST_OSC: begin
            if (tmr_done) begin
               if (dly_code == `CCSS_DLY_NONE) begin
                  state_d = ST_RUN;
               end else begin
                  state_d = ST_WDT;
                  tmr_ld_d = 1'b1;
                  tmr_val_d = wdt_cnt;
               end
            end
         end
         ST_WDT: begin
            if (tmr_done) state_d = ST_RUN;
         end
         ST_RUN: begin
            if (sleep_enter) state_d = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (wake_lvl) begin
               if ((slp_mode_q == `CCSS_SLP_PDOWN) || (slp_mode_q == `CCSS_SLP_PSAVE)) begin
                  state_d = ST_WAKE;
                  tmr_ld_d = 1'b1;
                  tmr_val_d = ck_of(cksel_q, sut_q);
               end else begin
                  state_d = ST_RUN;
               end
            end
         end
         ST_WAKE: begin
            if (tmr_done) state_d = ST_RUN;
         end
         default: state_d = ST_FUSE;
      endcase
   end

   // Sequencer registers; sleep mode frozen on entry
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_FUSE;
         tmr_ld_q <= 1'b0;
         tmr_val_q <= 17'h00000;
         slp_mode_q <= `CCSS_SLP_IDLE;
      end else begin
         state_q <= state_d;
         tmr_ld_q <= tmr_ld_d;
         tmr_val_q <= tmr_val_d;
         if ((state_q == ST_RUN) && sleep_enter) begin
            slp_mode_q <= ctrl_q[`CCSS_CTRL_MODE_LSB+2:`CCSS_CTRL_MODE_LSB];
         end
      end
   end

   // ---------------------------------------------------------------
   // Clock domain gating and source outputs
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_reset_n <= 1'b0;
         exec_hold <= 1'b1;
         cpu_clk_en <= 1'b0;
         flash_clk_en <= 1'b0;
         io_clk_en <= 1'b0;
         asy_clk_en <= 1'b0;
         adc_clk_en <= 1'b0;
         osc_sel <= `CCSS_SRC_IRC;
         amp_full_swing <= 1'b0;
         xtal_range <= 2'h0;
      end else begin
         if (state_d == ST_RUN) core_reset_n <= 1'b1;
         exec_hold <= (state_d != ST_RUN);
         // Core and flash stop in every sleep mode
         cpu_clk_en <= (state_d == ST_RUN);
         flash_clk_en <= (state_d == ST_RUN);
         if (state_d == ST_RUN) begin
            io_clk_en <= ctrl_q[`CCSS_CTRL_IO_EN];
            asy_clk_en <= ctrl_q[`CCSS_CTRL_ASY_EN];
            adc_clk_en <= ctrl_q[`CCSS_CTRL_ADC_EN];
         end else if (state_d == ST_SLEEP) begin
            io_clk_en <= ctrl_q[`CCSS_CTRL_IO_EN] && (slp_mode_now == `CCSS_SLP_IDLE);
            asy_clk_en <= ctrl_q[`CCSS_CTRL_ASY_EN] && (slp_mode_now != `CCSS_SLP_PDOWN)
               && (slp_mode_now != `CCSS_SLP_STBY);
            adc_clk_en <= ctrl_q[`CCSS_CTRL_ADC_EN] && ((slp_mode_now == `CCSS_SLP_IDLE)
               || (slp_mode_now == `CCSS_SLP_ADCNR));
         end else begin
            io_clk_en <= 1'b0;
            adc_clk_en <= 1'b0;
            asy_clk_en <= ctrl_q[`CCSS_CTRL_ASY_EN] && (state_d == ST_WAKE);
         end
         osc_sel <= src_of(cksel_q);
         amp_full_swing <= !opt_q;
         if (src_of(cksel_q) != `CCSS_SRC_XTAL) xtal_range <= 2'h0;
         else if (!opt_q) xtal_range <= 2'h3;
         else if (cksel_q[3:1] == 3'h5) xtal_range <= 2'h0;
         else if (cksel_q[3:1] == 3'h6) xtal_range <= 2'h1;
         else xtal_range <= 2'h2;
      end
   end

   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   // Control register write
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `CCSS_CTRL_RST;
      end else if (wr && (addr == `CCSS_REG_CTRL)) begin
         ctrl_q <= {2'h0, wdata[5:0]};
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         if (addr == `CCSS_REG_CTRL) rdata <= ctrl_q;
         else if (addr == `CCSS_REG_STAT) rdata <= {xtal_range, osc_sel, state_q};
         else if (addr == `CCSS_REG_FUSE) rdata <= {1'b0, opt_q, sut_q, cksel_q};
         else rdata <= 8'h00;
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// File: tb/ccss_checker.sv
// Concurrent checks on the clock select and start-up block.
// Assumes it is bound to ccss_top and sees only its ports.
`timescale 1ns/1ps
module ccss_checker #(
   parameter WDT_SHORT = 4096,
   parameter WDT_LONG = 65536
) (
   input wire clk,
   input wire rst_n,
   input wire [3:0] clock_source_select_fuses,
   input wire oscillator_amplifier_option_fuse,
   input wire sleep_enter,
   input wire core_reset_n,
   input wire exec_hold,
   input wire cpu_clk_en,
   input wire flash_clk_en,
   input wire [2:0] osc_sel,
   input wire amp_full_swing,
   input wire [1:0] xtal_range
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   function automatic [2:0] dec_src(input [3:0] c);
      if (c >= 4'hA) dec_src = 3'h0;
      else if (c == 4'h9) dec_src = 3'h1;
      else if (c >= 4'h5) dec_src = 3'h2;
      else if (c != 4'h0) dec_src = 3'h3;
      else dec_src = 3'h4;
   endfunction
   sequence s_start;
      $rose(core_reset_n);
   endsequence
   sequence s_sleep;
      sleep_enter && cpu_clk_en;
   endsequence

   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   property p_src;
      s_start |-> osc_sel == dec_src(clock_source_select_fuses);
   endproperty
   property p_amp;
      s_start |-> amp_full_swing == !oscillator_amplifier_option_fuse;
   endproperty
   property p_range;
      $rose(core_reset_n) && clock_source_select_fuses >= 4'hA |-> xtal_range ==
         (oscillator_amplifier_option_fuse ? clock_source_select_fuses[2:1] + 2'h3 : 2'h3);
   endproperty
   property p_flash;
      flash_clk_en == cpu_clk_en;
   endproperty
   property p_hold;
      exec_hold != cpu_clk_en;
   endproperty
   property p_cpu_rst;
      cpu_clk_en |-> core_reset_n;
   endproperty
   property p_rst_stay;
      core_reset_n |=> core_reset_n;
   endproperty
   property p_fuse_hold;
      core_reset_n ##1 core_reset_n |->
         $stable(osc_sel) && $stable(amp_full_swing) && $stable(xtal_range);
   endproperty
   property p_sleep;
      s_sleep |-> ##[1:2] !cpu_clk_en;
   endproperty
   a_src: assert property (p_src) else $error("source decode wrong");
   a_amp: assert property (p_amp) else $error("amplifier swing wrong");
   a_range: assert property (p_range) else $error("crystal range wrong");
   a_flash: assert property (p_flash) else $error("flash clock apart");
   a_hold: assert property (p_hold) else $error("hold and core clock clash");
   a_cpu_rst: assert property (p_cpu_rst) else $error("core clock in reset");
   a_rst_stay: assert property (p_rst_stay) else $error("reset came back");
   a_fuse_hold: assert property (p_fuse_hold) else $error("fuse outputs moved");
   a_sleep: assert property (p_sleep) else $error("core clock kept in sleep");
endmodule

// File: tb/ccss_osc_model.sv
// Model of the oscillator and the watchdog oscillator at the pins.
// Assumes the bench calls the burst tasks; both lines rest low between them.
`timescale 1ns/1ps
module ccss_osc_model #(
   // Half periods span over two system clocks so the three-stage sync sees every level
   parameter OSC_HALF = 250,
   parameter WDT_HALF = 330
) (
   output logic osc_clk_pin,
   output logic watchdog_oscillator_pin
);
   // Lines stand still until a burst is asked for
   initial begin
      osc_clk_pin = 1'b0;
      watchdog_oscillator_pin = 1'b0;
   end
   // Exact number of periods, phase unrelated to the system clock
   task automatic osc_burst(input int n);
      repeat (n) begin
         #(OSC_HALF) osc_clk_pin = 1'b1;
         #(OSC_HALF) osc_clk_pin = 1'b0;
      end
   endtask
   task automatic wdt_burst(input int n);
      repeat (n) begin
         #(WDT_HALF) watchdog_oscillator_pin = 1'b1;
         #(WDT_HALF) watchdog_oscillator_pin = 1'b0;
      end
   endtask
endmodule

// File: tb/ccss_top_tb_top.sv
// Self-checking bench for the clock select and start-up block.
// Assumes the oscillator model on the pins; reads are checked from a queue.
`timescale 1ns/1ps
`include "ccss_consts.vh"
module ccss_top_tb_top;
   localparam int WS = 8;
   localparam int WL = 16;
   logic clk, rst_n, opt, wake, slp, wr, rd, osc, wdt, rd_q1;
   logic core_rn, hold, cpu, flash, io, asy, adc, amp;
   logic [3:0] ck;
   logic [1:0] startup_fuse_field, xr;
   logic [2:0] src;
   logic [7:0] addr, wdata, rdata;
   logic [7:0] exp_q[$];
   int error_cnt, tests_run, seed, i;
   int t_ck[8] = '{1, 10, 10, 11, 9, 5, 0, 1};
   int t_sut[8] = '{0, 0, 2, 0, 0, 3, 1, 2};
   int t_n[8] = '{6, 258, 1024, 1024, 1024, 6, 6, 6};
   int t_w[8] = '{0, WS, 0, WL, WS, WS, WS, WL};
   int s_md[6] = '{0, 1, 2, 3, 6, 7};
   int s_g[6] = '{7, 3, 0, 1, 0, 1};

   ccss_top #(.WDT_SHORT(WS), .WDT_LONG(WL)) u_dut (
      .clk(clk), .rst_n(rst_n), .clock_source_select_fuses(ck),
      .startup_time_fuses(startup_fuse_field), .oscillator_amplifier_option_fuse(opt),
      .osc_clk_pin(osc), .watchdog_oscillator_pin(wdt), .wake_pin(wake),
      .sleep_enter(slp), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .core_reset_n(core_rn), .exec_hold(hold), .cpu_clk_en(cpu),
      .flash_clk_en(flash), .io_clk_en(io), .asy_clk_en(asy), .adc_clk_en(adc),
      .osc_sel(src), .amp_full_swing(amp), .xtal_range(xr));
   ccss_osc_model u_osc (.osc_clk_pin(osc), .watchdog_oscillator_pin(wdt));

   // ------------------------------------------------
   // Checking and closing
   // ------------------------------------------------
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   function automatic logic [2:0] dec(input logic [3:0] c);
      if (c >= 4'hA) return `CCSS_SRC_XTAL;
      if (c == 4'h9) return `CCSS_SRC_LFXT;
      if (c >= 4'h5) return `CCSS_SRC_ERC;
      if (c != 4'h0) return `CCSS_SRC_IRC;
      return `CCSS_SRC_EXT;
   endfunction
   // Read data stands in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_q1) begin
         check("rdata", rdata, exp_q.pop_front());
      end
      rd_q1 <= rd;
   end

   // ------------------------------------------------
   // Drivers
   // ------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic boot(input logic [3:0] c, input logic [1:0] s);
      @(posedge clk);
      rst_n <= 1'b0;
      ck <= c;
      startup_fuse_field <= s;
      opt <= 1'($random(seed));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // Wait boundedly for the core clock to reach the expected state
   task automatic settle(input logic e, input string nm);
      if (e) for (int k = 0; k < 12 && cpu !== e; k++) @(posedge clk);
      else repeat (12) @(posedge clk);
      check(nm, {7'h0, cpu}, {7'h0, e});
   endtask
   task automatic start(input int j);
      boot(4'(t_ck[j]), 2'(t_sut[j]));
      u_osc.osc_burst(t_n[j] - 1);
      settle(1'b0, "early release");
      u_osc.osc_burst(1);
      if (t_w[j] > 0) begin
         settle(1'b0, "delay skipped");
         u_osc.wdt_burst(t_w[j] - 1);
         settle(1'b0, "delay short");
         u_osc.wdt_burst(1);
      end
      settle(1'b1, "release");
   endtask

   // ------------------------------------------------
   // Stimulus
   // ------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      seed = 32'hd05f;
      {rst_n, opt, wake, slp, wr, rd} = 6'h00;
      {ck, startup_fuse_field, addr, wdata} = 22'h0;
      // Every fuse code, random option and start-up fuses
      for (i = 0; i < 16; i++) begin
         boot(4'(i), 2'($random(seed)));
         check("source", {5'h0, src}, {5'h0, dec(4'(i))});
         check("swing", {7'h0, amp}, {7'h0, ~opt});
         if (i >= 10) check("range", {6'h0, xr}, {6'h0, opt ? 2'((i - 10) / 2) : 2'h3});
         rd_reg(`CCSS_REG_FUSE, {1'b0, opt, startup_fuse_field, 4'(i)});
      end
      // Start-up counts per source, last one factory default
      for (i = 0; i < 8; i++) start(i);
      rd_reg(`CCSS_REG_CTRL, `CCSS_CTRL_RST);
      ck <= 4'hE;
      startup_fuse_field <= 2'h1;
      wr_reg(`CCSS_REG_FUSE, 8'h00);
      rd_reg(`CCSS_REG_FUSE, {1'b0, opt, `CCSS_FUSE_SUT_DFLT, `CCSS_FUSE_CKSEL_DFLT});
      rd_reg(8'h07, 8'h00);
      check("held source", {5'h0, src}, {5'h0, `CCSS_SRC_IRC});
      wr_reg(`CCSS_REG_CTRL, 8'hFF);
      rd_reg(`CCSS_REG_CTRL, 8'h3F);
      // Each sleep mode: gates, then wake with or without start-up count
      for (i = 0; i < 6; i++) begin
         wr_reg(`CCSS_REG_CTRL, {5'h07, 3'(s_md[i])});
         slp <= 1'b1;
         @(posedge clk);
         slp <= 1'b0;
         repeat (4) @(posedge clk);
         check("gates", {4'h0, cpu, io, adc, asy}, {5'h0, 3'(s_g[i])});
         wake <= 1'b1;
         if (s_md[i] == 2 || s_md[i] == 3) begin
            repeat (8) @(posedge clk);
            u_osc.osc_burst(5);
            settle(1'b0, "early wake");
            u_osc.osc_burst(1);
         end
         settle(1'b1, "wake");
         wake <= 1'b0;
         repeat (6) @(posedge clk);
      end
      end_sim();
   end
   // Hang guard
   initial begin
      #(100 * 60000);
      error_cnt++;
      end_sim();
   end
endmodule

bind ccss_top ccss_checker #(.WDT_SHORT(WDT_SHORT), .WDT_LONG(WDT_LONG)) u_chk (
   .clk(clk), .rst_n(rst_n), .clock_source_select_fuses(clock_source_select_fuses),
   .oscillator_amplifier_option_fuse(oscillator_amplifier_option_fuse),
   .sleep_enter(sleep_enter), .core_reset_n(core_reset_n), .exec_hold(exec_hold),
   .cpu_clk_en(cpu_clk_en), .flash_clk_en(flash_clk_en), .osc_sel(osc_sel),
   .amp_full_swing(amp_full_swing), .xtal_range(xtal_range));
